//--- design/mfs_top.v
// The address map and register access over APB are this design's own decisions.
`include "mfs_consts.vh"
`default_nettype none
module mfs_top #(
    parameter CNT_W = 16,
    parameter POS_W = 32
) (
    // clock and reset
    input  wire          i_sys_clk,
    input  wire          i_rst,
    // apb slave
    input  wire          i_psel,
    input  wire          i_penable,
    input  wire          i_pwrite,
    input  wire [7:0]    i_paddr,
    input  wire [31:0]   i_pwdata,
    output wire [31:0]   o_prdata,
    output wire          o_pready,
    output wire          o_pslverr,
    // encoder pins per axis
    input  wire [3:0]    i_enc_phase_a_pos,
    input  wire [3:0]    i_enc_phase_a_neg,
    input  wire [3:0]    i_enc_phase_b_pos,
    input  wire [3:0]    i_enc_phase_b_neg,
    input  wire [3:0]    i_enc_index_pos,
    input  wire [3:0]    i_enc_index_neg,
    // external pulse commands, active low
    input  wire [3:0]    i_ext_cmd_forward,
    input  wire [3:0]    i_ext_cmd_reverse,
    // emergency stop and polarity jumper
    input  wire          i_emergency_stop_in,
    input  wire          i_estop_polarity_select,
    // drive outputs and interrupt
    output wire [3:0]    o_drv_pulse,
    output wire [3:0]    o_drv_dir,
    output wire          o_irq
);
    localparam NA = 4;
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_FIX  = 3'b010;
    localparam [2:0] ST_JOG  = 3'b100;

    function addr_hit;
        input [7:0] a;
        begin
            addr_hit = (a[1:0] == 2'b00) && (a <= `MFS_OFS_POS3);
        end
    endfunction

    // positive high with negative low reads as an internal low
    function pair_level;
        input p;
        input n;
        begin
            pair_level = ~(p & ~n);
        end
    endfunction

    reg  [31:0]      prdata_q;
    reg              pready_q;
    reg              pslverr_q;
    reg  [31:0]      ctrl_q;
    reg  [CNT_W-1:0] preset_q;
    reg  [CNT_W-1:0] period_q;
    reg  [8:0]       irq_stat_q;
    reg  [8:0]       irq_en_q;
    reg              irq_q;
    reg  [1:0]       es_sync_q;
    reg  [1:0]       pol_sync_q;
    reg  [1:0]       fill_q;
    reg              estop_q;
    reg  [31:0]      rd_d;
    reg  [8:0]       irq_stat_d;

    wire [NA*POS_W-1:0] pos_w;
    wire [NA-1:0]       busy_w;
    wire [NA-1:0]       idx_lvl_w;
    wire [NA-1:0]       idx_ev_w;
    wire [NA-1:0]       done_ev_w;

    wire acc    = i_psel & i_penable;
    wire wr_en  = acc & pready_q & i_pwrite & addr_hit(i_paddr);
    wire wr_cmd = wr_en && (i_paddr == `MFS_OFS_CMD);
    wire wr_clr = wr_en && (i_paddr == `MFS_OFS_IRQ_CLR);

    // jumper low: active when shorted to ground; high: active when open
    // ignored until the chains hold real pin samples, so reset raises no false event
    wire estop_act = fill_q[1] & (pol_sync_q[1] ? es_sync_q[1] : ~es_sync_q[1]);
    wire ev_estop  = estop_act & ~estop_q;

    assign o_prdata  = prdata_q;
    assign o_pready  = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_irq     = irq_q;

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            es_sync_q  <= 2'b00;
            pol_sync_q <= 2'b00;
            fill_q     <= 2'b00;
            estop_q    <= 1'b0;
        end else begin
            es_sync_q  <= {es_sync_q[0], i_emergency_stop_in};
            // the jumper may be moved with power on, so it is synchronised too
            pol_sync_q <= {pol_sync_q[0], i_estop_polarity_select};
            fill_q     <= {fill_q[0], 1'b1};
            estop_q    <= estop_act;
        end
    end

    always @* begin
        rd_d = 32'h0000_0000;
        if (i_paddr == `MFS_OFS_CTRL) begin
            rd_d = ctrl_q;
        end else if (i_paddr == `MFS_OFS_STATUS) begin
            rd_d[`MFS_ST_ERR]        = irq_stat_q[`MFS_IRQ_ESTOP];
            rd_d[`MFS_ST_ESTOP]      = estop_q;
            rd_d[`MFS_ST_BUSY+:NA]   = busy_w;
            rd_d[`MFS_ST_IDX+:NA]    = idx_lvl_w;
        end else if (i_paddr == `MFS_OFS_PRESET) begin
            rd_d[CNT_W-1:0] = preset_q;
        end else if (i_paddr == `MFS_OFS_PERIOD) begin
            rd_d[CNT_W-1:0] = period_q;
        end else if (i_paddr == `MFS_OFS_IRQ_STAT) begin
            rd_d[8:0] = irq_stat_q;
        end else if (i_paddr == `MFS_OFS_IRQ_EN) begin
            rd_d[8:0] = irq_en_q;
        end else if (i_paddr >= `MFS_OFS_POS0 && i_paddr <= `MFS_OFS_POS3 &&
                     addr_hit(i_paddr)) begin
            rd_d[POS_W-1:0] = pos_w[i_paddr[3:2]*POS_W+:POS_W];
        end
    end

    // set wins over a clear in the same cycle
    always @* begin
        irq_stat_d = irq_stat_q;
        if (wr_clr) begin
            irq_stat_d = irq_stat_d & ~i_pwdata[8:0];
        end
        irq_stat_d[`MFS_IRQ_ESTOP] = irq_stat_d[`MFS_IRQ_ESTOP] | ev_estop;
        irq_stat_d[`MFS_IRQ_IDX+:NA]  = irq_stat_d[`MFS_IRQ_IDX+:NA] | idx_ev_w;
        irq_stat_d[`MFS_IRQ_DONE+:NA] = irq_stat_d[`MFS_IRQ_DONE+:NA] | done_ev_w;
    end

    // one wait state: ready rises in the second access cycle
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            prdata_q   <= 32'h0000_0000;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
            ctrl_q     <= `MFS_CTRL_RST;
            preset_q   <= `MFS_PRESET_RST;
            period_q   <= `MFS_PERIOD_RST;
            irq_stat_q <= 9'h000;
            irq_en_q   <= 9'h000;
            irq_q      <= 1'b0;
        end else begin
            pready_q   <= acc & ~pready_q;
            if (acc & ~pready_q) begin
                prdata_q  <= i_pwrite ? 32'h0000_0000 : rd_d;
                pslverr_q <= ~addr_hit(i_paddr);
            end
            if (wr_en && i_paddr == `MFS_OFS_CTRL) begin
                ctrl_q <= i_pwdata;
            end
            if (wr_en && i_paddr == `MFS_OFS_PRESET) begin
                preset_q <= i_pwdata[CNT_W-1:0];
            end
            if (wr_en && i_paddr == `MFS_OFS_PERIOD) begin
                period_q <= i_pwdata[CNT_W-1:0];
            end
            if (wr_en && i_paddr == `MFS_OFS_IRQ_EN) begin
                irq_en_q <= i_pwdata[8:0];
            end
            irq_stat_q <= irq_stat_d;
            irq_q      <= |(irq_stat_d & irq_en_q);
        end
    end

    genvar g;
    generate
        for (g = 0; g < NA; g = g + 1) begin : g_axis
            reg  [2:0]       a_q;
            reg  [2:0]       b_q;
            reg  [2:0]       z_q;
            reg  [2:0]       f_q;
            reg  [2:0]       r_q;
            reg  [POS_W-1:0] pos_q;
            reg  [2:0]       st_q;
            reg  [CNT_W-1:0] tmr_q;
            reg  [CNT_W-1:0] rem_q;
            reg              pulse_q;
            reg              dir_q;
            reg              done_q;
            // each line of a pair gets two stages of its own before the merge,
            // so an edge on one line cannot reach the counters unsettled
            reg  [1:0]       ap_q;
            reg  [1:0]       an_q;
            reg  [1:0]       bp_q;
            reg  [1:0]       bn_q;
            reg  [1:0]       zp_q;
            reg  [1:0]       zn_q;


            // positive high with negative low reads as internal low
            wire a_in = pair_level(ap_q[1], an_q[1]);
            wire b_in = pair_level(bp_q[1], bn_q[1]);
            wire z_in = pair_level(zp_q[1], zn_q[1]);

            wire ud    = ctrl_q[`MFS_CTRL_UD+g];
            wire [1:0] em = ctrl_q[`MFS_CTRL_EXT+2*g+:2];
            // sampling every clock gives far more than four samples per phase
            wire q_ev  = a_q[1] ^ a_q[2] ^ b_q[1] ^ b_q[2];
            wire q_up  = a_q[1] ^ b_q[2];
            wire u_ev  = a_q[2] & ~a_q[1];
            wire d_ev  = b_q[2] & ~b_q[1];
            wire inc   = ud ? (u_ev & ~d_ev) : (q_ev & q_up);
            wire dec   = ud ? (d_ev & ~u_ev) : (q_ev & ~q_up);
            wire z_ev  = z_q[2] & ~z_q[1];
            wire f_lo  = ~f_q[1];
            wire r_lo  = ~r_q[1];
            wire f_act = f_q[2] & f_lo;
            wire r_act = r_q[2] & r_lo;
            wire sw_f  = wr_cmd & i_pwdata[`MFS_CMD_FWD+g];
            wire sw_r  = wr_cmd & i_pwdata[`MFS_CMD_REV+g];
            wire idx_k = z_ev & ctrl_q[`MFS_CTRL_IDXSTP+g];
            wire kill  = estop_act | estop_q | idx_k |
                         (wr_cmd & i_pwdata[`MFS_CMD_STOP+g]);
            wire tick  = (tmr_q >= period_q);
            wire rel   = dir_q ? ~f_lo : ~r_lo;
            wire pre_z = (preset_q == {CNT_W{1'b0}});

            assign pos_w[g*POS_W+:POS_W] = pos_q;
            assign busy_w[g]    = ~st_q[0];
            assign idx_lvl_w[g] = z_q[1];
            assign idx_ev_w[g]  = z_ev;
            assign done_ev_w[g] = done_q;
            assign o_drv_pulse[g] = pulse_q;
            assign o_drv_dir[g]   = dir_q;

            always @(posedge i_sys_clk) begin
                if (i_rst) begin
                    a_q   <= 3'b111;
                    b_q   <= 3'b111;
                    z_q   <= 3'b111;
                    f_q   <= 3'b111;
                    r_q   <= 3'b111;
                    ap_q  <= 2'b00;
                    an_q  <= 2'b11;
                    bp_q  <= 2'b00;
                    bn_q  <= 2'b11;
                    zp_q  <= 2'b00;
                    zn_q  <= 2'b11;
                    pos_q <= {POS_W{1'b0}};
                end else begin
                    ap_q  <= {ap_q[0], i_enc_phase_a_pos[g]};
                    an_q  <= {an_q[0], i_enc_phase_a_neg[g]};
                    bp_q  <= {bp_q[0], i_enc_phase_b_pos[g]};
                    bn_q  <= {bn_q[0], i_enc_phase_b_neg[g]};
                    zp_q  <= {zp_q[0], i_enc_index_pos[g]};
                    zn_q  <= {zn_q[0], i_enc_index_neg[g]};
                    // a pin edge reaches the position counter five clocks later
                    a_q   <= {a_q[1:0], a_in};
                    b_q   <= {b_q[1:0], b_in};
                    z_q   <= {z_q[1:0], z_in};
                    f_q   <= {f_q[1:0], i_ext_cmd_forward[g]};
                    r_q   <= {r_q[1:0], i_ext_cmd_reverse[g]};
                    if (wr_en && i_paddr == `MFS_OFS_POS0 + 8'd4 * g) begin
                        pos_q <= i_pwdata[POS_W-1:0];
                    end else if (inc) begin
                        pos_q <= pos_q + 1'b1;
                    end else if (dec) begin
                        pos_q <= pos_q - 1'b1;
                    end
                end
            end

            // drive engine runs on its own once started
            always @(posedge i_sys_clk) begin
                if (i_rst) begin
                    st_q    <= ST_IDLE;
                    tmr_q   <= {CNT_W{1'b0}};
                    rem_q   <= {CNT_W{1'b0}};
                    pulse_q <= 1'b0;
                    dir_q   <= 1'b0;
                    done_q  <= 1'b0;
                end else begin
                    done_q <= 1'b0;
                    tmr_q  <= tick ? {CNT_W{1'b0}} : tmr_q + 1'b1;
                    case (st_q)
                        ST_IDLE: begin
                            tmr_q   <= {CNT_W{1'b0}};
                            pulse_q <= 1'b0;
                            rem_q   <= preset_q;
                            if (kill) begin
                                st_q <= ST_IDLE;
                            end else if ((sw_f | sw_r) & ~pre_z) begin
                                st_q  <= ST_FIX;
                                dir_q <= sw_f;
                            end else if (em == `MFS_EXT_HAND && (f_act | r_act) && ~pre_z) begin
                                st_q  <= ST_FIX;
                                dir_q <= f_act;
                            end else if (em == `MFS_EXT_JOG && (f_lo | r_lo)) begin
                                st_q  <= ST_JOG;
                                dir_q <= f_lo;
                            end
                        end
                        ST_FIX: begin
                            if (kill) begin
                                st_q    <= ST_IDLE;
                                pulse_q <= 1'b0;
                                done_q  <= 1'b1;
                            end else if (tick) begin
                                pulse_q <= ~pulse_q;
                                if (pulse_q) begin
                                    rem_q <= rem_q - 1'b1;
                                    if (rem_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                                        st_q   <= ST_IDLE;
                                        done_q <= 1'b1;
                                    end
                                end
                            end
                        end
                        ST_JOG: begin
                            // release ends the drive without cutting a pulse short
                            if (kill || (rel && !pulse_q)) begin
                                st_q    <= ST_IDLE;
                                pulse_q <= 1'b0;
                                done_q  <= 1'b1;
                            end else if (tick) begin
                                pulse_q <= ~pulse_q;
                            end
                        end
                        default: begin
                            st_q    <= ST_IDLE;
                            pulse_q <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

//--- design/mfs_consts.vh
`ifndef MFS_CONSTS_VH
`define MFS_CONSTS_VH

// register byte offsets
`define MFS_OFS_CTRL     8'h00
`define MFS_OFS_STATUS   8'h04
`define MFS_OFS_PRESET   8'h08
`define MFS_OFS_PERIOD   8'h0c
`define MFS_OFS_CMD      8'h10
`define MFS_OFS_IRQ_STAT 8'h14
`define MFS_OFS_IRQ_CLR  8'h18
`define MFS_OFS_IRQ_EN   8'h1c
`define MFS_OFS_POS0     8'h20
`define MFS_OFS_POS3     8'h2c

// control fields: up/down mode, index stop, external mode
`define MFS_CTRL_UD      0
`define MFS_CTRL_IDXSTP  4
`define MFS_CTRL_EXT     8
`define MFS_EXT_OFF      2'd0
`define MFS_EXT_JOG      2'd1
`define MFS_EXT_HAND     2'd2

// command fields
`define MFS_CMD_FWD      0
`define MFS_CMD_REV      4
`define MFS_CMD_STOP     8

// status and interrupt fields
`define MFS_ST_ERR       0
`define MFS_ST_ESTOP     1
`define MFS_ST_BUSY      2
`define MFS_ST_IDX       6
`define MFS_IRQ_ESTOP    0
`define MFS_IRQ_IDX      1
`define MFS_IRQ_DONE     5

// reset values
`define MFS_CTRL_RST     32'h0000_0000
`define MFS_PRESET_RST   16'h0001
`define MFS_PERIOD_RST   16'h0018

// timing
`define MFS_SYS_CLK_HZ   50000000
`define MFS_ENC_MAX_HZ   1000000
`define MFS_ENC_EDGE_CYC (`MFS_SYS_CLK_HZ / (4 * `MFS_ENC_MAX_HZ))
`endif

//--- dv/mfs_checker_assertions.sv
`default_nettype none
module mfs_checker (
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_emergency_stop_in,
    input wire logic        i_estop_polarity_select,
    input wire logic [3:0]  o_drv_pulse,
    input wire logic [3:0]  o_drv_dir,
    input wire logic        o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // jumper low means the stop acts while the pin is held low
    wire logic stop_act = (i_emergency_stop_in == i_estop_polarity_select);

    a_pready_one_wait: assert property ((i_psel && !i_penable) ##1 (i_psel && i_penable)
        |=> o_pready) else $error("pready missing after one wait state");
    a_pready_single: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    a_pready_request: assert property (o_pready |-> i_psel && i_penable)
        else $error("pready without access phase");
    a_slverr_map: assert property (o_pready |->
        o_pslverr == (i_paddr[1:0] != 2'b00 || i_paddr > 8'h2c))
        else $error("pslverr does not match address map");
    a_unmapped_zero: assert property (o_pready && o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
        else $error("unmapped read data not zero");
    a_prdata_hold: assert property (!o_pready |-> $stable(o_prdata))
        else $error("read data moved outside an answer");
    a_estop_halt: assert property (stop_act [*4] |-> o_drv_pulse == 4'h0)
        else $error("drive pulse while stop active");
    a_reset_idle: assert property ($fell(i_rst) |-> o_drv_pulse == 4'h0 && !o_irq && !o_pready)
        else $error("outputs not idle after reset");
    a_dir_steady: assert property ((o_drv_pulse & (o_drv_dir ^ $past(o_drv_dir))) == 4'h0)
        else $error("direction changed during pulse");
endmodule

bind mfs_top mfs_checker u_chk (.i_sys_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .o_prdata, .o_pready, .o_pslverr, .i_emergency_stop_in, .i_estop_polarity_select,
    .o_drv_pulse, .o_drv_dir, .o_irq);
`default_nettype wire

//--- dv/mfs_far_end.sv
`default_nettype none
module mfs_far_end (
    // clock
    input  wire logic       i_sys_clk,
    // encoder line driver
    output logic [3:0]      o_enc_phase_a_pos,
    output logic [3:0]      o_enc_phase_a_neg,
    output logic [3:0]      o_enc_phase_b_pos,
    output logic [3:0]      o_enc_phase_b_neg,
    output logic [3:0]      o_enc_index_pos,
    output logic [3:0]      o_enc_index_neg,
    // jog unit and stop switch
    output logic [3:0]      o_ext_cmd_forward = 4'hf,
    output logic [3:0]      o_ext_cmd_reverse = 4'hf,
    output logic            o_emergency_stop_in = 1'b1,
    output logic            o_estop_polarity_select = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // 13 cycles per phase edge keeps the encoder at or below its top rate
    localparam int EDGE_CYC = 13;
    localparam logic [1:0] SEQ [4] = '{2'b11, 2'b01, 2'b00, 2'b10};
    logic [3:0] int_a = 4'hf;
    logic [3:0] int_b = 4'hf;
    logic [3:0] int_z = 4'hf;
    int         ph [4] = '{0, 0, 0, 0};
    assign o_enc_phase_a_pos = ~int_a;
    assign o_enc_phase_a_neg = int_a;
    assign o_enc_phase_b_pos = ~int_b;
    assign o_enc_phase_b_neg = int_b;
    assign o_enc_index_pos = ~int_z;
    assign o_enc_index_neg = int_z;

    task automatic quad_step(input int ax, input int fwd);
        ph[ax] = (ph[ax] + (fwd ? 1 : 3)) % 4;
        int_a[ax] <= SEQ[ph[ax]][1];
        int_b[ax] <= SEQ[ph[ax]][0];
        repeat (EDGE_CYC) @(posedge i_sys_clk);
    endtask
    // rising edges only, so parking never counts in up/down mode
    task automatic park;
        int_a <= 4'hf;
        int_b <= 4'hf;
        ph = '{default: 0};
        repeat (EDGE_CYC) @(posedge i_sys_clk);
    endtask
    task automatic ud_pulse(input int ax, input int up);
        if (up) int_a[ax] <= 1'b0;
        else int_b[ax] <= 1'b0;
        repeat (EDGE_CYC) @(posedge i_sys_clk);
        park();
    endtask
    task automatic idx(input int ax, input logic lvl);
        int_z[ax] <= lvl;
        repeat (EDGE_CYC) @(posedge i_sys_clk);
    endtask
    task automatic cmd(input int ax, input int fwd, input logic lvl);
        if (fwd) o_ext_cmd_forward[ax] <= lvl;
        else o_ext_cmd_reverse[ax] <= lvl;
        repeat (10) @(posedge i_sys_clk);
    endtask
    task automatic estop(input logic sel, input logic act);
        o_estop_polarity_select <= sel;
        o_emergency_stop_in <= act ? sel : ~sel;
        repeat (10) @(posedge i_sys_clk);
    endtask
endmodule
`default_nettype wire

//--- dv/test_motion_feedback_and_stop_inputs.sv
`default_nettype none
module test_motion_feedback_and_stop_inputs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_sys_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
    logic        i_pwrite = 1'b0, rerr;
    logic [7:0]  i_paddr = 8'h0;
    logic [31:0] i_pwdata = 32'h0, rdat;
    wire  [31:0] o_prdata;
    wire         o_pready, o_pslverr, o_irq, i_emergency_stop_in, i_estop_polarity_select;
    wire  [3:0]  o_drv_pulse, o_drv_dir, i_ext_cmd_forward, i_ext_cmd_reverse;
    wire  [3:0]  i_enc_phase_a_pos, i_enc_phase_a_neg, i_enc_phase_b_pos, i_enc_phase_b_neg;
    wire  [3:0]  i_enc_index_pos, i_enc_index_neg;
    int          errors = 0, check_count = 0;
    int          pcnt [4] = '{0, 0, 0, 0};
    logic [3:0]  prev_p = 4'h0;

    mfs_top DUT (.i_sys_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_enc_phase_a_pos, .i_enc_phase_a_neg,
        .i_enc_phase_b_pos, .i_enc_phase_b_neg, .i_enc_index_pos, .i_enc_index_neg,
        .i_ext_cmd_forward, .i_ext_cmd_reverse, .i_emergency_stop_in,
        .i_estop_polarity_select, .o_drv_pulse, .o_drv_dir, .o_irq);
    mfs_far_end fe (.i_sys_clk, .o_enc_phase_a_pos(i_enc_phase_a_pos),
        .o_enc_phase_a_neg(i_enc_phase_a_neg), .o_enc_phase_b_pos(i_enc_phase_b_pos),
        .o_enc_phase_b_neg(i_enc_phase_b_neg), .o_enc_index_pos(i_enc_index_pos),
        .o_enc_index_neg(i_enc_index_neg), .o_ext_cmd_forward(i_ext_cmd_forward),
        .o_ext_cmd_reverse(i_ext_cmd_reverse), .o_emergency_stop_in(i_emergency_stop_in),
        .o_estop_polarity_select(i_estop_polarity_select));

    initial begin
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        prev_p <= o_drv_pulse;
        for (int k = 0; k < 4; k++) begin
            if (o_drv_pulse[k] === 1'b1 && prev_p[k] === 1'b0) pcnt[k]++;
        end
    end

    function automatic logic [31:0] ext_mode(int ax, int mode);
        return 32'(mode) << (8 + 2 * ax);
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= adr;
        i_pwdata <= wd;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 40);
        if (o_pready !== 1'b1) chk("pready", 32'h1, 32'h0);
        rdat = o_prdata;
        rerr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
        apb(1'b0, adr, 32'h0);
        chk(what, exp, rdat);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, 8'h04, 32'h0);
            n++;
        end while (rdat[5:2] !== 4'h0 && n < 300);
        chk("busy", 32'h0, {28'h0, rdat[5:2]});
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #1ms;
        errors++;
        close_out();
    end
    initial begin
        int seed, n, c;
        int exp [4];
        logic [15:0] pre;
        seed = $urandom(47);
        repeat (16) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        rd(8'h00, 32'h0, "ctrl");
        rd(8'h08, 32'h1, "preset");
        rd(8'h0c, 32'h18, "period");
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped", 32'h1, {31'h0, rerr});
        apb(1'b1, 8'h02, 32'h0);
        chk("misaligned", 32'h1, {31'h0, rerr});
        // pass 0 quadrature, pass 1 up/down counting
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, 8'h00, m ? 32'hf : 32'h0);
            if (m) fe.park();
            for (int ax = 0; ax < 4; ax++) begin
                apb(1'b1, 8'(8'h20 + 4 * ax), 32'h0);
                exp[ax] = 0;
                n = 4 + $urandom % 12;
                repeat (n) begin
                    c = $urandom % 2;
                    if (m) fe.ud_pulse(ax, c);
                    else fe.quad_step(ax, c);
                    exp[ax] += c ? 1 : -1;
                end
            end
            repeat (4) @(posedge i_sys_clk);
            for (int ax = 0; ax < 4; ax++) rd(8'(8'h20 + 4 * ax), exp[ax], "pos");
        end
        apb(1'b1, 8'h20, 32'h5a);
        rd(8'h20, 32'h5a, "pos write");
        apb(1'b0, 8'h21, 32'h0);
        chk("misaligned read", 32'h1, {31'h0, rerr});
        chk("misaligned data", 32'h0, rdat);
        apb(1'b1, 8'h1c, 32'h1ff);
        apb(1'b1, 8'h18, 32'h1ff);
        fe.idx(2, 1'b0);
        rd(8'h04, 32'h2c0, "index level");
        fe.idx(2, 1'b1);
        rd(8'h14, 32'h8, "index event");
        chk("irq set", 32'h1, {31'h0, o_irq});
        apb(1'b1, 8'h18, 32'h8);
        repeat (2) @(posedge i_sys_clk);
        chk("irq cleared", 32'h0, {31'h0, o_irq});
        apb(1'b1, 8'h1c, 32'h0);
        fe.idx(2, 1'b0);
        fe.idx(2, 1'b1);
        rd(8'h14, 32'h8, "masked event");
        chk("irq masked", 32'h0, {31'h0, o_irq});
        apb(1'b1, 8'h0c, 32'h2);
        pre = 16'(1 + $urandom % 6);
        apb(1'b1, 8'h08, {16'h0, pre});
        apb(1'b1, 8'h00, ext_mode(0, 2) | ext_mode(1, 1));
        pcnt = '{default: 0};
        fe.cmd(0, 0, 1'b0);
        fe.cmd(0, 0, 1'b1);
        wait_idle();
        chk("hand pulses", {16'h0, pre}, pcnt[0]);
        chk("hand dir", 32'h0, {31'h0, o_drv_dir[0]});
        fe.cmd(1, 1, 1'b0);
        repeat (50) @(posedge i_sys_clk);
        chk("jog running", 32'h1, {31'h0, pcnt[1] >= 7});
        fe.cmd(1, 1, 1'b1);
        wait_idle();
        c = pcnt[1];
        repeat (40) @(posedge i_sys_clk);
        chk("jog stopped", c, pcnt[1]);
        chk("jog dir", 32'h1, {31'h0, o_drv_dir[1]});
        apb(1'b1, 8'h00, 32'h80);
        apb(1'b1, 8'h10, 32'h8);
        wait_idle();
        chk("cmd pulses", {16'h0, pre}, pcnt[3]);
        apb(1'b1, 8'h08, 32'hffff);
        apb(1'b1, 8'h10, 32'h8);
        repeat (20) @(posedge i_sys_clk);
        fe.idx(3, 1'b0);
        c = pcnt[3];
        repeat (30) @(posedge i_sys_clk);
        chk("index stop", c, pcnt[3]);
        fe.idx(3, 1'b1);
        apb(1'b1, 8'h1c, 32'h1);
        for (int p = 0; p < 2; p++) begin
            fe.estop(p[0], 1'b0);
            apb(1'b1, 8'h18, 32'h1ff);
            apb(1'b1, 8'h10, 32'hf);
            repeat (20) @(posedge i_sys_clk);
            fe.estop(p[0], 1'b1);
            c = pcnt.sum();
            repeat (30) @(posedge i_sys_clk);
            chk("estop halt", c, pcnt.sum());
            apb(1'b0, 8'h04, 32'h0);
            chk("error flag", 32'h1, {31'h0, rdat[0]});
            chk("estop irq", 32'h1, {31'h0, o_irq});
            fe.estop(p[0], 1'b0);
        end
        close_out();
    end
endmodule
`default_nettype wire
